/* include/spc_pkg.sv */
// Constants shared by the serial port control and baud timing block.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package spc_pkg;
	localparam logic [7:0] OFF_TX_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_RX_STATUS_CONTROL = 8'h04;
	localparam logic [7:0] OFF_BAUD_CONTROL = 8'h08;
	localparam logic [7:0] OFF_RECEIVE_DATA = 8'h0c;
	localparam logic [7:0] OFF_BAUD_PERIOD_LOW = 8'h10;
	localparam logic [7:0] OFF_BAUD_PERIOD_HIGH = 8'h14;
	// Bit positions shared by the three control registers.
	localparam int B7 = 7;
	localparam int B6 = 6;
	localparam int B5 = 5;
	localparam int B4 = 4;
	localparam int B3 = 3;
	localparam int B2 = 2;
	localparam int B1 = 1;
	localparam int B0 = 0;
	localparam logic RST_TX_SHIFT_EMPTY = 1'b1;
	localparam logic RST_RECEIVE_IDLE = 1'b1;
	localparam logic RST_CTRL_BIT = 1'b0;
	localparam logic [7:0] RST_PERIOD = 8'h00;
	// Baud multipliers, as the last index of timer overflows per bit (count minus one).
	localparam logic [5:0] MULT_LOW = 6'h3f;
	localparam logic [5:0] MULT_MID = 6'h0f;
	localparam logic [5:0] MULT_HIGH = 6'h03;
	localparam int FIFO_DEPTH = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spc_pkg

/* core/spc_baud_timer.sv */
// Free-running baud timer with the bit-rate multiplier behind it.
// Assumes the caller pulses clear on any period write or port disable.
`timescale 1ns/1ps
module spc_baud_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic sixteen_bit_select,
	input wire logic [15:0] period,
	input wire logic [5:0] mult_last,
	output logic timer_tick,
	output logic bit_tick
);
	logic [15:0] count_reg;
	logic [5:0] mult_reg;
	logic [15:0] reload;
	logic at_zero;

	// The 8-bit timer ignores the high period byte.
	assign reload = sixteen_bit_select ? period : {8'h00, period[7:0]};
	assign at_zero = (count_reg == 16'h0000);
	assign timer_tick = at_zero & ~clear;
	assign bit_tick = timer_tick & (mult_reg >= mult_last);

	// A clear restarts the count at once; on a period write the reload still uses the old period.
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			count_reg <= reload;
		end else if (at_zero) begin
			count_reg <= reload;
		end else begin
			count_reg <= count_reg - 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			mult_reg <= 6'h00;
		end else if (bit_tick) begin
			mult_reg <= 6'h00;
		end else if (timer_tick) begin
			mult_reg <= mult_reg + 6'h01;
		end
	end
endmodule : spc_baud_timer

/* core/spc_core.sv */
// Control, status and baud timing of a serial port, on AXI4-Lite.
// Assumes external bit shifters and auto-baud logic give level or
// one-cycle pulse status on the shifter ports, synchronous to aclk.
// Functional notes
// - Sync mode: clock source bit one means master clock, zero slave.
// - Transmit nine-bit bit picks nine bits; ninth data bit supplies it.
// - Port mode bit set means synchronous, clear means asynchronous.
// - Async break request sends a break; hardware clears it when done.
// - Async high-speed bit picks multiplier with sixteen-bit bit.
// - Transmit shift empty bit reads shifter empty state; resets to one.
// - In sync mode continuous receive, or single receive in master, overrides transmit enable.
// - Port enable claims pins; clear resets flags, self-clearing bits, buffer and baud timer; other bits and the period keep their values.
// - Receive nine-bit bit picks nine bits; ninth bit shown in status.
// - Single receive in sync master does one reception, then clears.
// - Continuous receive enables receiver; in sync overrides single.
// - Async nine-bit address detect keeps only ninth-bit-one characters.
// - Framing error bit follows the character at the buffer head.
// - Overrun bit set on overrun, cleared by clearing continuous receive.
// - Async auto-baud overflow bit set on auto-baud timer overflow.
// - Async receive idle flag is zero while a character arrives.
// - Polarity bit inverts async data, picks sync clock edge.
// - Baud timer is 8-bit by default, 16-bit when selected.
// - Async wake-up waits for falling edge, sets receive flag, clears.
// - Async auto-baud enable starts detection; hardware clears it.
// - Any write to a period byte restarts the baud timer at once.
// - Baud divides by 64, 16 or 4 times period plus one.
// - Two-character buffer; third character sets overrun, stops reception.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spc_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic port_active,
	output logic sync_mode,
	output logic sync_master,
	output logic clock_rising_edge,
	output logic transmit_active,
	output logic tx_nine_bits,
	output logic tx_ninth_bit,
	output logic break_pending,
	output logic receive_active,
	output logic rx_nine_bits,
	output logic wakeup_armed,
	output logic autobaud_armed,
	output logic receive_flag,
	output logic baud_timer_tick,
	output logic baud_bit_tick,
	input wire logic tx_shift_empty_in,
	input wire logic break_done,
	input wire logic tx_line_data,
	input wire logic sync_clock_out,
	input wire logic rx_busy,
	input wire logic rx_char_valid,
	input wire logic [8:0] rx_char_data,
	input wire logic rx_char_framing_error,
	input wire logic rx_falling_edge,
	input wire logic autobaud_done,
	input wire logic autobaud_overflow,
	output logic transmit_clock_pin_o,
	output logic transmit_clock_pin_oe,
	output logic receive_data_pin_oe
);
	logic clock_source_select_reg, tx_nine_bit_select_reg;
	logic transmit_enable_bit_reg, sync_mode_reg, break_request_reg;
	logic high_speed_select_reg, tx_shift_empty_reg, tx_ninth_data_bit_reg;
	logic port_enable_reg, rx_nine_bit_select_reg, single_receive_enable_reg;
	logic continuous_receive_enable_reg, address_detect_enable_reg;
	logic overrun_error_flag_reg, autobaud_overflow_flag_reg;
	logic receive_idle_flag_reg, clock_data_polarity_reg;
	logic sixteen_bit_select_reg, wakeup_enable_reg, autobaud_enable_reg;
	logic wake_flag_reg;
	logic [7:0] period_low_reg, period_high_reg;
	logic [8:0] fifo_data_reg [0:spc_pkg::FIFO_DEPTH-1];
	logic fifo_framing_error_flag_reg [0:spc_pkg::FIFO_DEPTH-1];
	logic [1:0] fifo_count_reg;
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_lane_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	// Bus decode.
	wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire wr_en = do_write & w_lane_reg;
	wire wr_tx = wr_en & (aw_addr_reg == spc_pkg::OFF_TX_STATUS_CONTROL);
	wire wr_rx = wr_en & (aw_addr_reg == spc_pkg::OFF_RX_STATUS_CONTROL);
	wire wr_bd = wr_en & (aw_addr_reg == spc_pkg::OFF_BAUD_CONTROL);
	wire wr_pl = wr_en & (aw_addr_reg == spc_pkg::OFF_BAUD_PERIOD_LOW);
	wire wr_ph = wr_en & (aw_addr_reg == spc_pkg::OFF_BAUD_PERIOD_HIGH);
	wire wr_hit = (aw_addr_reg == spc_pkg::OFF_TX_STATUS_CONTROL)
		| (aw_addr_reg == spc_pkg::OFF_RX_STATUS_CONTROL)
		| (aw_addr_reg == spc_pkg::OFF_BAUD_CONTROL)
		| (aw_addr_reg == spc_pkg::OFF_RECEIVE_DATA)
		| (aw_addr_reg == spc_pkg::OFF_BAUD_PERIOD_LOW)
		| (aw_addr_reg == spc_pkg::OFF_BAUD_PERIOD_HIGH);
	wire rd_take = s_axi_arvalid & ~rvalid_reg;
	wire [7:0] rd_addr = s_axi_araddr[7:0];
	wire rd_word = (s_axi_araddr[31:8] == 24'h000000);
	wire wr_word = 1'b1;

	// Mode decode.
	wire held = ~port_enable_reg;
	wire async_on = ~sync_mode_reg;
	wire master = sync_mode_reg & clock_source_select_reg;
	wire single_on = master & single_receive_enable_reg;
	wire rx_on = port_enable_reg & (continuous_receive_enable_reg
		| (sync_mode_reg & single_on));
	wire tx_on = port_enable_reg & transmit_enable_bit_reg
		& ~(sync_mode_reg & (single_on | continuous_receive_enable_reg));
	wire addr_ok = ~(async_on & rx_nine_bit_select_reg
		& address_detect_enable_reg) | rx_char_data[8];
	wire wake_mode = async_on & wakeup_enable_reg;
	wire char_in = rx_char_valid & rx_on & ~wake_mode;
	wire full = (fifo_count_reg == 2'd2);
	wire fifo_pop = rd_take & rd_word & (rd_addr == spc_pkg::OFF_RECEIVE_DATA)
		& (fifo_count_reg != 2'd0);
	wire fifo_push = char_in & addr_ok & ~overrun_error_flag_reg
		& (~full | fifo_pop);
	wire overrun_set = char_in & addr_ok & ~overrun_error_flag_reg & full
		& ~fifo_pop;
	wire wake_hit = wake_mode & port_enable_reg & rx_falling_edge;
	wire [1:0] push_slot = fifo_pop ? fifo_count_reg - 2'd1 : fifo_count_reg;
	wire [1:0] count_next = fifo_count_reg + {1'b0, fifo_push}
		- {1'b0, fifo_pop};
	wire [5:0] mult_last = sync_mode_reg ? spc_pkg::MULT_HIGH
		: sixteen_bit_select_reg ? (high_speed_select_reg
		? spc_pkg::MULT_HIGH : spc_pkg::MULT_MID)
		: (high_speed_select_reg ? spc_pkg::MULT_MID : spc_pkg::MULT_LOW);
	wire head_full = (fifo_count_reg != 2'd0);
	wire head_framing_error_flag = head_full & fifo_framing_error_flag_reg[0];
	wire head_ninth = head_full & fifo_data_reg[0][8];
	// An empty buffer reads zero rather than a stale entry.
	wire [7:0] head_byte = head_full ? fifo_data_reg[0][7:0] : 8'h00;

	wire [7:0] tx_view = {clock_source_select_reg, tx_nine_bit_select_reg,
		transmit_enable_bit_reg, sync_mode_reg, break_request_reg,
		high_speed_select_reg, tx_shift_empty_reg, tx_ninth_data_bit_reg};
	wire [7:0] rx_view = {port_enable_reg, rx_nine_bit_select_reg,
		single_receive_enable_reg, continuous_receive_enable_reg,
		address_detect_enable_reg, head_framing_error_flag, overrun_error_flag_reg,
		head_ninth};
	wire [7:0] bd_view = {autobaud_overflow_flag_reg, receive_idle_flag_reg,
		1'b0, clock_data_polarity_reg, sixteen_bit_select_reg, 1'b0,
		wakeup_enable_reg, autobaud_enable_reg};
	wire [7:0] rd_byte =
		(rd_addr == spc_pkg::OFF_TX_STATUS_CONTROL) ? tx_view
		: (rd_addr == spc_pkg::OFF_RX_STATUS_CONTROL) ? rx_view
		: (rd_addr == spc_pkg::OFF_BAUD_CONTROL) ? bd_view
		: (rd_addr == spc_pkg::OFF_RECEIVE_DATA) ? head_byte
		: (rd_addr == spc_pkg::OFF_BAUD_PERIOD_LOW) ? period_low_reg
		: period_high_reg;
	wire rd_hit = rd_word & ((rd_addr == spc_pkg::OFF_TX_STATUS_CONTROL)
		| (rd_addr == spc_pkg::OFF_RX_STATUS_CONTROL)
		| (rd_addr == spc_pkg::OFF_BAUD_CONTROL)
		| (rd_addr == spc_pkg::OFF_RECEIVE_DATA)
		| (rd_addr == spc_pkg::OFF_BAUD_PERIOD_LOW)
		| (rd_addr == spc_pkg::OFF_BAUD_PERIOD_HIGH));

	// AXI4-Lite slave: address and data are caught separately.
	assign s_axi_awready = ~aw_held_reg;
	assign s_axi_wready = ~w_held_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && !aw_held_reg) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= (s_axi_awaddr[31:8] == 24'h000000)
				? s_axi_awaddr[7:0] : 8'hff;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end else if (s_axi_wvalid && !w_held_reg) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_lane_reg <= s_axi_wstrb[0] & wr_word;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= spc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= spc_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
			rresp_reg <= rd_hit ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Transmit control; hardware clears of write-one bits lose to a set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_source_select_reg <= spc_pkg::RST_CTRL_BIT;
			tx_nine_bit_select_reg <= spc_pkg::RST_CTRL_BIT;
			transmit_enable_bit_reg <= spc_pkg::RST_CTRL_BIT;
			sync_mode_reg <= spc_pkg::RST_CTRL_BIT;
			high_speed_select_reg <= spc_pkg::RST_CTRL_BIT;
			tx_ninth_data_bit_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (wr_tx) begin
			clock_source_select_reg <= w_data_reg[spc_pkg::B7];
			tx_nine_bit_select_reg <= w_data_reg[spc_pkg::B6];
			transmit_enable_bit_reg <= w_data_reg[spc_pkg::B5];
			sync_mode_reg <= w_data_reg[spc_pkg::B4];
			high_speed_select_reg <= w_data_reg[spc_pkg::B2];
			tx_ninth_data_bit_reg <= w_data_reg[spc_pkg::B0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			break_request_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (wr_tx) begin
			break_request_reg <= w_data_reg[spc_pkg::B3];
		end else if (break_done) begin
			break_request_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			tx_shift_empty_reg <= spc_pkg::RST_TX_SHIFT_EMPTY;
		end else begin
			tx_shift_empty_reg <= tx_shift_empty_in;
		end
	end

	// Receive control.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_enable_reg <= spc_pkg::RST_CTRL_BIT;
			rx_nine_bit_select_reg <= spc_pkg::RST_CTRL_BIT;
			continuous_receive_enable_reg <= spc_pkg::RST_CTRL_BIT;
			address_detect_enable_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (wr_rx) begin
			port_enable_reg <= w_data_reg[spc_pkg::B7];
			rx_nine_bit_select_reg <= w_data_reg[spc_pkg::B6];
			continuous_receive_enable_reg <= w_data_reg[spc_pkg::B4];
			address_detect_enable_reg <= w_data_reg[spc_pkg::B3];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			single_receive_enable_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (wr_rx) begin
			single_receive_enable_reg <= w_data_reg[spc_pkg::B5];
		end else if (single_on && !continuous_receive_enable_reg
			&& rx_char_valid) begin
			single_receive_enable_reg <= 1'b0;
		end
	end

	// Overrun set wins over the clear made by dropping continuous receive.
	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			overrun_error_flag_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (overrun_set) begin
			overrun_error_flag_reg <= 1'b1;
		end else if (!continuous_receive_enable_reg) begin
			overrun_error_flag_reg <= 1'b0;
		end
	end

	// Two-entry receive buffer; entry 0 is the head.
	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			fifo_count_reg <= 2'd0;
		end else begin
			fifo_count_reg <= count_next;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < spc_pkg::FIFO_DEPTH; gi++) begin : g_slot
			always_ff @(posedge aclk) begin
				if (!aresetn || held) begin
					fifo_data_reg[gi] <= 9'h000;
					fifo_framing_error_flag_reg[gi] <= 1'b0;
				end else if (fifo_push && push_slot == 2'(gi)) begin
					fifo_data_reg[gi] <= {rx_nine_bit_select_reg & rx_char_data[8],
						rx_char_data[7:0]};
					fifo_framing_error_flag_reg[gi] <= rx_char_framing_error;
				end else if (fifo_pop && gi < spc_pkg::FIFO_DEPTH - 1) begin
					fifo_data_reg[gi] <= fifo_data_reg[(gi + 1) % spc_pkg::FIFO_DEPTH];
					fifo_framing_error_flag_reg[gi] <= fifo_framing_error_flag_reg[(gi + 1) % spc_pkg::FIFO_DEPTH];
				end
			end
		end
	endgenerate

	// Baud control.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_data_polarity_reg <= spc_pkg::RST_CTRL_BIT;
			sixteen_bit_select_reg <= spc_pkg::RST_CTRL_BIT;
		end else if (wr_bd) begin
			clock_data_polarity_reg <= w_data_reg[spc_pkg::B4];
			sixteen_bit_select_reg <= w_data_reg[spc_pkg::B3];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			wakeup_enable_reg <= spc_pkg::RST_CTRL_BIT;
			wake_flag_reg <= 1'b0;
		end else begin
			wakeup_enable_reg <= wr_bd ? w_data_reg[spc_pkg::B1]
				: wakeup_enable_reg & ~wake_hit;
			wake_flag_reg <= wake_hit | (wake_flag_reg & ~(rd_take & rd_word
				& rd_addr == spc_pkg::OFF_RECEIVE_DATA));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held) begin
			autobaud_enable_reg <= spc_pkg::RST_CTRL_BIT;
			autobaud_overflow_flag_reg <= spc_pkg::RST_CTRL_BIT;
		end else begin
			autobaud_enable_reg <= wr_bd ? w_data_reg[spc_pkg::B0]
				: autobaud_enable_reg & ~autobaud_done;
			autobaud_overflow_flag_reg <= autobaud_overflow_flag_reg
				| (async_on & autobaud_enable_reg & autobaud_overflow);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || held || !async_on) begin
			receive_idle_flag_reg <= spc_pkg::RST_RECEIVE_IDLE;
		end else begin
			receive_idle_flag_reg <= ~(rx_on & rx_busy);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_low_reg <= spc_pkg::RST_PERIOD;
			period_high_reg <= spc_pkg::RST_PERIOD;
		end else begin
			period_low_reg <= wr_pl ? w_data_reg : period_low_reg;
			period_high_reg <= wr_ph ? w_data_reg : period_high_reg;
		end
	end

	spc_baud_timer u_baud_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(held | wr_pl | wr_ph),
		.sixteen_bit_select(sixteen_bit_select_reg),
		.period({period_high_reg, period_low_reg}),
		.mult_last(mult_last),
		.timer_tick(baud_timer_tick),
		.bit_tick(baud_bit_tick)
	);

	// Shifter controls and pin steering.
	assign port_active = port_enable_reg;
	assign sync_mode = sync_mode_reg;
	assign sync_master = master;
	assign clock_rising_edge = sync_mode_reg & clock_data_polarity_reg;
	assign transmit_active = tx_on;
	assign tx_nine_bits = tx_nine_bit_select_reg;
	assign tx_ninth_bit = tx_ninth_data_bit_reg;
	assign break_pending = async_on & break_request_reg & port_enable_reg;
	assign receive_active = rx_on & ~overrun_error_flag_reg & ~wake_mode;
	assign rx_nine_bits = rx_nine_bit_select_reg;
	assign wakeup_armed = wake_mode & port_enable_reg;
	assign autobaud_armed = async_on & autobaud_enable_reg & port_enable_reg;
	assign receive_flag = rx_on & (head_full | wake_flag_reg);
	assign transmit_clock_pin_o = async_on
		? tx_line_data ^ clock_data_polarity_reg : sync_clock_out;
	assign transmit_clock_pin_oe = port_enable_reg & (async_on | master);
	assign receive_data_pin_oe = port_enable_reg & sync_mode_reg & tx_on;
endmodule : spc_core

/* sim/spc_far_model.sv */
// Far-side model: bit shifters, auto-baud unit and receive line.
// Assumes the bench calls its tasks from a process clocked by aclk.
`timescale 1ns/1ps
module spc_far_model (
	input wire logic aclk,
	output logic tx_shift_empty_in,
	output logic break_done,
	output logic tx_line_data,
	output logic sync_clock_out,
	output logic rx_busy,
	output logic rx_char_valid,
	output logic [8:0] rx_char_data,
	output logic rx_char_framing_error,
	output logic rx_falling_edge,
	output logic autobaud_done,
	output logic autobaud_overflow
);
	logic [3:0] ev;
	assign {autobaud_overflow, autobaud_done, rx_falling_edge, break_done} = ev;
	assign tx_shift_empty_in = 1'b1;
	assign tx_line_data = 1'b1;
	assign sync_clock_out = 1'b0;
	initial begin
		ev = 4'h0;
		rx_busy = 1'b0;
		rx_char_valid = 1'b0;
		rx_char_data = 9'h0;
		rx_char_framing_error = 1'b0;
	end
	task automatic send_char(input logic [8:0] v, input logic fe);
		@(posedge aclk);
		rx_busy <= 1'b1;
		repeat (4) @(posedge aclk);
		rx_busy <= 1'b0;
		rx_char_valid <= 1'b1;
		rx_char_data <= v;
		rx_char_framing_error <= fe;
		@(posedge aclk);
		rx_char_valid <= 1'b0;
		// Released data no longer shows the character.
		rx_char_data <= ~v;
		rx_char_framing_error <= ~fe;
	endtask : send_char
	task automatic pulse(input logic [3:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 4'h0;
	endtask : pulse
	task automatic busy(input logic b);
		@(posedge aclk);
		rx_busy <= b;
	endtask : busy
endmodule : spc_far_model

/* sim/spc_core_sva.sv */
// Checker for the spc_core control outputs.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module spc_core_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic port_active,
	input wire logic sync_mode,
	input wire logic sync_master,
	input wire logic clock_rising_edge,
	input wire logic transmit_active,
	input wire logic break_pending,
	input wire logic receive_active,
	input wire logic wakeup_armed,
	input wire logic receive_flag,
	input wire logic break_done,
	input wire logic transmit_clock_pin_oe,
	input wire logic receive_data_pin_oe
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_off;
		!port_active |-> !receive_flag && !transmit_active && !receive_active;
	endproperty
	a_off: assert property (p_off) else $error("port off but active");
	property p_pins;
		!port_active |-> !transmit_clock_pin_oe && !receive_data_pin_oe;
	endproperty
	a_pins: assert property (p_pins) else $error("pins driven");
	property p_rx_wins;
		sync_mode && receive_active |-> !transmit_active;
	endproperty
	a_rx_wins: assert property (p_rx_wins) else $error("tx beat rx");
	property p_master;
		sync_master |-> sync_mode;
	endproperty
	a_master: assert property (p_master) else $error("master async");
	property p_edge;
		clock_rising_edge |-> sync_mode;
	endproperty
	a_edge: assert property (p_edge) else $error("edge in async");
	property p_brk;
		break_pending |-> !sync_mode && port_active;
	endproperty
	a_brk: assert property (p_brk) else $error("break in sync");
	property p_brk_clr;
		break_pending && break_done |=> !break_pending || $rose(s_axi_bvalid);
	endproperty
	a_brk_clr: assert property (p_brk_clr) else $error("break stuck");
	property p_wake;
		wakeup_armed && !sync_mode |-> !receive_active;
	endproperty
	a_wake: assert property (p_wake) else $error("rx in wake");
endmodule : spc_core_sva
bind spc_core spc_core_sva chk_u (.*);

/* sim/tb.sv */
// Testbench: register bus driver, scoreboard and scenarios.
// Assumes spc_core, spc_far_model and the bound checker are compiled.
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] TXC = spc_pkg::OFF_TX_STATUS_CONTROL;
	localparam logic [7:0] RXC = spc_pkg::OFF_RX_STATUS_CONTROL;
	localparam logic [7:0] BDC = spc_pkg::OFF_BAUD_CONTROL;
	localparam logic [7:0] RXD = spc_pkg::OFF_RECEIVE_DATA;
	localparam logic [7:0] PLO = spc_pkg::OFF_BAUD_PERIOD_LOW;
	localparam logic [7:0] PHI = spc_pkg::OFF_BAUD_PERIOD_HIGH;
	localparam logic [1:0] OK = spc_pkg::RESP_OKAY;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic port_active, sync_mode, sync_master, clock_rising_edge;
	logic transmit_active, tx_nine_bits, tx_ninth_bit, break_pending;
	logic receive_active, rx_nine_bits, wakeup_armed, autobaud_armed;
	logic receive_flag, baud_timer_tick, baud_bit_tick, tx_shift_empty_in;
	logic break_done, tx_line_data, sync_clock_out, rx_busy, rx_char_valid;
	logic [8:0] rx_char_data;
	logic rx_char_framing_error, rx_falling_edge, autobaud_done;
	logic autobaud_overflow, transmit_clock_pin_o, transmit_clock_pin_oe;
	logic receive_data_pin_oe;
	logic [33:0] exp_q[$];
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 94563;
	int g;
	logic [7:0] d;
	logic [7:0] ad[5] = '{TXC, RXC, BDC, PLO, PHI};
	logic [7:0] wm[5] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff};
	logic [7:0] km[5] = '{8'hf5, 8'h58, 8'h18, 8'hff, 8'hff};
	logic [7:0] sm[5] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};
	logic [7:0] bt[5] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90};
	logic [7:0] bb[5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h10};
	int bg[5] = '{256, 64, 4160, 1040, 16};
	spc_core dut_u (.*);
	spc_far_model far_u (.*);
	initial aclk = 1'b0;
	always #2.5 aclk = ~aclk;
	task automatic chk(input string nm, input logic [33:0] e,
		input logic [33:0] v);
		n_checks++;
		if (v !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	function automatic logic [33:0] pop();
		if (exp_q.size() == 0) return 'x;
		return exp_q.pop_front();
	endfunction : pop
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		if (n == 100) bad_count++;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		n = 0;
		@(posedge aclk);
		exp_q.push_back(e);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		if (n == 100) bad_count++;
	endtask : rd
	task automatic gap(output int t);
		int n;
		n = 0;
		do @(posedge aclk); while (baud_bit_tick !== 1'b1 && ++n < 5000);
		t = 0;
		do begin
			@(posedge aclk);
			t++;
		end while (baud_bit_tick !== 1'b1 && t < 5000);
	endtask : gap
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			chk("read", pop(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk("bresp", pop(), {s_axi_bresp, 32'h0});
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(TXC, 34'h2);
		rd(BDC, 34'h40);
		rd(8'h18, {spc_pkg::RESP_SLVERR, 32'h0});
		wr(8'h18, 8'hff, spc_pkg::RESP_SLVERR);
		for (int i = 0; i < 5; i++) begin
			d = 8'($random(seed)) & wm[i];
			wr(ad[i], d, OK);
			rd(ad[i], {26'h0, d & km[i] | sm[i]});
		end
		$display("test registers done");
		wr(TXC, 8'h00, OK);
		wr(BDC, 8'h00, OK);
		wr(RXC, 8'h90, OK);
		far_u.send_char(9'h031, 1'b1);
		far_u.send_char(9'h032, 1'b0);
		far_u.send_char(9'h033, 1'b0);
		rd(RXC, 34'h96);
		rd(RXD, 34'h31);
		rd(RXC, 34'h92);
		rd(RXD, 34'h32);
		wr(RXC, 8'h80, OK);
		rd(RXC, 34'h80);
		rd(RXD, 34'h0);
		$display("test overrun done");
		wr(RXC, 8'hd8, OK);
		far_u.send_char(9'h055, 1'b0);
		@(posedge aclk);
		chk("flag", 34'h0, {33'h0, receive_flag});
		far_u.send_char(9'h1a5, 1'b0);
		rd(RXC, 34'hd9);
		rd(RXD, 34'ha5);
		rd(RXD, 34'h0);
		$display("test address done");
		wr(TXC, 8'h28, OK);
		rd(TXC, 34'h2a);
		far_u.pulse(4'h1);
		rd(TXC, 34'h22);
		$display("test break done");
		wr(RXC, 8'h90, OK);
		wr(PLO, 8'h03, OK);
		wr(PHI, 8'h01, OK);
		for (int i = 0; i < 5; i++) begin
			wr(TXC, bt[i], OK);
			wr(BDC, bb[i], OK);
			gap(g);
			gap(g);
			chk("bit gap", {2'h0, bg[i]}, {2'h0, g});
		end
		$display("test baud done");
		wr(TXC, 8'h00, OK);
		wr(BDC, 8'h02, OK);
		rd(BDC, 34'h42);
		far_u.pulse(4'h2);
		@(posedge aclk);
		chk("wake flag", 34'h1, {33'h0, receive_flag});
		rd(BDC, 34'h40);
		wr(BDC, 8'h01, OK);
		far_u.pulse(4'hc);
		rd(BDC, 34'hc0);
		far_u.busy(1'b1);
		repeat (3) @(posedge aclk);
		rd(BDC, 34'h80);
		far_u.busy(1'b0);
		rd(BDC, 34'hc0);
		$display("test wake done");
		wr(TXC, 8'hb0, OK);
		wr(RXC, 8'ha0, OK);
		chk("pins", 34'h1,
			{32'h0, transmit_active, transmit_clock_pin_oe});
		far_u.send_char(9'h077, 1'b0);
		rd(RXC, 34'h80);
		rd(RXD, 34'h77);
		$display("test single done");
		summarize();
	end
endmodule : tb
